// ===== rtl/terminal_cond_pkg.sv
// Notes on behaviour
// - Out11, out12 and relay each wait their own on-delay, 0..1000 in 0.1 s steps.
// - The same three outputs each wait their own off-delay, 0..1000 in 0.1 s steps.
// - Combiner operator code 0 is AND, 1 is OR, 2 is XOR.
// - Operands accept any function code except combiner codes, option-board output, none.
// - Three independent combiners, each with two operand selectors and one operator.
// - Inputs 1..7 change only after raw level held for their 0..200 filter time.
// - Speed selection taken only after it stays stable for its 0..200 settle time.
// - Second overload threshold, 0..2000 in 0.1 %, compared with output current.
`default_nettype none
package terminal_cond_pkg;

    // Parameter register numbers
    localparam logic [15:0] ADDR_OVL_THR = 16'h1473;
    localparam logic [15:0] ADDR_OUT11_ON = 16'h1486;
    localparam logic [15:0] ADDR_OUT11_OFF = 16'h1487;
    localparam logic [15:0] ADDR_OUT12_ON = 16'h1488;
    localparam logic [15:0] ADDR_OUT12_OFF = 16'h1489;
    localparam logic [15:0] ADDR_RELAY_ON = 16'h1490;
    localparam logic [15:0] ADDR_RELAY_OFF = 16'h1491;
    localparam logic [15:0] ADDR_COMB1_A = 16'h1492;
    localparam logic [15:0] ADDR_COMB1_B = 16'h1493;
    localparam logic [15:0] ADDR_COMB1_OP = 16'h1494;
    localparam logic [15:0] ADDR_COMB2_A = 16'h1495;
    localparam logic [15:0] ADDR_COMB2_B = 16'h1496;
    localparam logic [15:0] ADDR_COMB2_OP = 16'h1497;
    localparam logic [15:0] ADDR_COMB3_A = 16'h1498;
    localparam logic [15:0] ADDR_COMB3_B = 16'h1499;
    localparam logic [15:0] ADDR_COMB3_OP = 16'h149A;
    localparam logic [15:0] ADDR_IN1_FILT = 16'h14A4;
    localparam logic [15:0] ADDR_IN2_FILT = 16'h14A5;
    localparam logic [15:0] ADDR_IN3_FILT = 16'h14A6;
    localparam logic [15:0] ADDR_IN4_FILT = 16'h14A7;
    localparam logic [15:0] ADDR_IN5_FILT = 16'h14A8;
    localparam logic [15:0] ADDR_IN6_FILT = 16'h14A9;
    localparam logic [15:0] ADDR_IN7_FILT = 16'h14AA;
    localparam logic [15:0] ADDR_MSEL_SETTLE = 16'h14AD;

    // Legal ranges and reset value
    localparam logic [15:0] THR_MAX = 16'h07D0;
    localparam logic [15:0] DELAY_MAX = 16'h03E8;
    localparam logic [15:0] FILT_MAX = 16'h00C8;
    localparam logic [15:0] OPER_MAX = 16'h0002;
    localparam logic [15:0] REG_RST = 16'h0000;

    // Output function codes
    localparam int FIDX_W = 6;
    localparam logic [15:0] FUNC_NUM = 16'h0040;
    localparam logic [15:0] FUNC_LOG_FIRST = 16'h0021;
    localparam logic [15:0] FUNC_LOG_LAST = 16'h0026;
    localparam logic [15:0] FUNC_OPT_BOARD = 16'h003F;
    localparam logic [15:0] FUNC_NONE = 16'h00FF;

    // Timing at 50 MHz
    localparam longint CLK_PERIOD_NS = 20;
    localparam longint DELAY_STEP_NS = 100_000_000;
    localparam longint SAMPLE_TICK_NS = 1_000_000;
    localparam int unsigned DELAY_STEP_CYC = int'(DELAY_STEP_NS / CLK_PERIOD_NS);
    localparam int unsigned SAMPLE_TICK_CYC = int'(SAMPLE_TICK_NS / CLK_PERIOD_NS);

    localparam int IN_NUM = 7;
    localparam int SEL_WIDTH = 4;
    localparam int COMB_NUM = 3;

    typedef enum logic [1:0] {OP_AND = 2'h0, OP_OR = 2'h1, OP_XOR = 2'h2} combine_op_t;

    typedef enum logic [1:0] {
        DLY_IDLE = 2'h0,
        DLY_ARM = 2'h1,
        DLY_HELD = 2'h3,
        DLY_DROP = 2'h2
    } delay_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic ack;
        logic err;
        logic [15:0] rdata;
    } reg_rsp_t;

    // Legal operand code check
    function automatic logic opnd_ok(input logic [15:0] code);
        return (code < FUNC_NUM) && !((code >= FUNC_LOG_FIRST) && (code <= FUNC_LOG_LAST))
            && (code != FUNC_OPT_BOARD) && (code != FUNC_NONE);
    endfunction

endpackage
`default_nettype wire

// ===== rtl/delay_timer.sv
`default_nettype none
module delay_timer
    import terminal_cond_pkg::*;
#(
    parameter int unsigned STEP_CYC = DELAY_STEP_CYC
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic src,
    input wire logic [15:0] on_dly,
    input wire logic [15:0] off_dly,
    output logic dout
);
    typedef struct packed {
        delay_state_t st;
        logic [31:0] pre;
        logic [15:0] steps;
    } dly_regs_t;

    dly_regs_t s_r;
    dly_regs_t s_nxt;

    // Step prescaler plus step counter per pending edge
    always_comb begin
        s_nxt = s_r;
        case (s_r.st)
            DLY_IDLE: begin
                s_nxt.pre = 32'h0000_0000;
                s_nxt.steps = 16'h0000;
                if (src) begin
                    s_nxt.st = (on_dly == 16'h0000) ? DLY_HELD : DLY_ARM;
                end
            end
            DLY_ARM: begin
                if (!src) begin
                    s_nxt.st = DLY_IDLE;
                end else if (s_r.pre == 32'(STEP_CYC - 1)) begin
                    s_nxt.pre = 32'h0000_0000;
                    if (16'(s_r.steps + 16'h0001) >= on_dly) begin
                        s_nxt.st = DLY_HELD;
                    end else begin
                        s_nxt.steps = 16'(s_r.steps + 16'h0001);
                    end
                end else begin
                    s_nxt.pre = s_r.pre + 32'h0000_0001;
                end
            end
            DLY_HELD: begin
                s_nxt.pre = 32'h0000_0000;
                s_nxt.steps = 16'h0000;
                if (!src) begin
                    s_nxt.st = (off_dly == 16'h0000) ? DLY_IDLE : DLY_DROP;
                end
            end
            default: begin
                if (src) begin
                    s_nxt.st = DLY_HELD;
                end else if (s_r.pre == 32'(STEP_CYC - 1)) begin
                    s_nxt.pre = 32'h0000_0000;
                    if (16'(s_r.steps + 16'h0001) >= off_dly) begin
                        s_nxt.st = DLY_IDLE;
                    end else begin
                        s_nxt.steps = 16'(s_r.steps + 16'h0001);
                    end
                end else begin
                    s_nxt.pre = s_r.pre + 32'h0000_0001;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_r <= '{st: DLY_IDLE, pre: 32'h0000_0000, steps: 16'h0000};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign dout = s_r.st[1]; // High in HELD and DROP

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    sequence s_arm_abort;
        s_r.st == DLY_ARM && !src;
    endsequence

    a_arm_cancel: assert property (
        s_arm_abort |=> s_r.st == DLY_IDLE && !dout)
        else $error("pending on-delay not cancelled");
endmodule
`default_nettype wire

// ===== rtl/settle_filter.sv
`default_nettype none
module settle_filter
    import terminal_cond_pkg::*;
#(
    parameter int unsigned W = 1,
    parameter int unsigned TICK_CYC = SAMPLE_TICK_CYC
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [W-1:0] raw,
    input wire logic [15:0] settle,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] out;
        logic [W-1:0] cand;
        logic [31:0] pre;
        logic [15:0] cnt;
    } filt_regs_t;

    filt_regs_t s_r;
    filt_regs_t s_nxt;

    // Restart on any change of the candidate level
    always_comb begin
        s_nxt = s_r;
        if (settle == 16'h0000) begin
            s_nxt.out = raw;
            s_nxt.cand = raw;
            s_nxt.pre = 32'h0000_0000;
            s_nxt.cnt = 16'h0000;
        end else if (raw == s_r.out) begin
            s_nxt.cand = s_r.out;
            s_nxt.pre = 32'h0000_0000;
            s_nxt.cnt = 16'h0000;
        end else if (raw != s_r.cand) begin
            s_nxt.cand = raw;
            s_nxt.pre = 32'h0000_0000;
            s_nxt.cnt = 16'h0000;
        end else if (s_r.pre == 32'(TICK_CYC - 1)) begin
            s_nxt.pre = 32'h0000_0000;
            if (16'(s_r.cnt + 16'h0001) >= settle) begin
                s_nxt.out = s_r.cand;
                s_nxt.cnt = 16'h0000;
            end else begin
                s_nxt.cnt = 16'(s_r.cnt + 16'h0001);
            end
        end else begin
            s_nxt.pre = s_r.pre + 32'h0000_0001;
        end
    end

    // State register
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign dout = s_r.out;

    a_fresh_level: assert property (@(posedge mclk) disable iff (sys_rst)
        settle != 16'h0000 && raw != s_r.cand |=> dout == $past(dout))
        else $error("filtered level moved without settling");
endmodule
`default_nettype wire

// ===== rtl/terminal_conditioner.sv
`default_nettype none
module terminal_conditioner
    import terminal_cond_pkg::*;
#(
    parameter int unsigned DELAY_STEP_CYC_P = DELAY_STEP_CYC,
    parameter int unsigned SAMPLE_TICK_CYC_P = SAMPLE_TICK_CYC
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire reg_req_t reg_req,
    output var reg_rsp_t reg_rsp,
    input wire logic out11_src,
    input wire logic out12_src,
    input wire logic relay_src,
    output logic out11_pin,
    output logic out12_pin,
    output logic relay_output,
    input wire logic [63:0] func_state,
    output logic [COMB_NUM-1:0] logic_out,
    input wire logic [IN_NUM-1:0] din_raw,
    output logic [IN_NUM-1:0] din_filt,
    input wire logic [SEL_WIDTH-1:0] msel_raw,
    output logic [SEL_WIDTH-1:0] msel_held,
    input wire logic [15:0] load_current,
    output logic ovl_warn2
);
    typedef enum logic [3:0] {
        K_NONE = 4'h0,
        K_THR = 4'h1,
        K_ON = 4'h2,
        K_OFF = 4'h3,
        K_OPA = 4'h4,
        K_OPB = 4'h5,
        K_OPER = 4'h6,
        K_FILT = 4'h7,
        K_MSEL = 4'h8
    } reg_kind_t;

    typedef struct packed {
        logic [15:0] thr;
        logic [COMB_NUM-1:0][15:0] dly_on;
        logic [COMB_NUM-1:0][15:0] dly_off;
        logic [COMB_NUM-1:0][15:0] opa;
        logic [COMB_NUM-1:0][15:0] opb;
        logic [COMB_NUM-1:0][1:0] oper;
        logic [IN_NUM-1:0][15:0] filt;
        logic [15:0] msel_settle;
        reg_rsp_t rsp;
        logic [COMB_NUM-1:0] lout;
        logic ovl;
    } top_regs_t;

    top_regs_t s_r;
    top_regs_t s_nxt;
    reg_kind_t kind;
    logic [2:0] idx;
    logic [COMB_NUM-1:0] opa_val;
    logic [COMB_NUM-1:0] opb_val;

    // Register number decode
    always_comb begin
        kind = K_NONE;
        idx = 3'h0;
        if (reg_req.addr == ADDR_OVL_THR) begin
            kind = K_THR;
        end else if (reg_req.addr == ADDR_OUT11_ON) begin
            kind = K_ON;
        end else if (reg_req.addr == ADDR_OUT11_OFF) begin
            kind = K_OFF;
        end else if (reg_req.addr == ADDR_OUT12_ON) begin
            kind = K_ON;
            idx = 3'h1;
        end else if (reg_req.addr == ADDR_OUT12_OFF) begin
            kind = K_OFF;
            idx = 3'h1;
        end else if (reg_req.addr == ADDR_RELAY_ON) begin
            kind = K_ON;
            idx = 3'h2;
        end else if (reg_req.addr == ADDR_RELAY_OFF) begin
            kind = K_OFF;
            idx = 3'h2;
        end else if (reg_req.addr == ADDR_COMB1_A) begin
            kind = K_OPA;
        end else if (reg_req.addr == ADDR_COMB1_B) begin
            kind = K_OPB;
        end else if (reg_req.addr == ADDR_COMB1_OP) begin
            kind = K_OPER;
        end else if (reg_req.addr == ADDR_COMB2_A) begin
            kind = K_OPA;
            idx = 3'h1;
        end else if (reg_req.addr == ADDR_COMB2_B) begin
            kind = K_OPB;
            idx = 3'h1;
        end else if (reg_req.addr == ADDR_COMB2_OP) begin
            kind = K_OPER;
            idx = 3'h1;
        end else if (reg_req.addr == ADDR_COMB3_A) begin
            kind = K_OPA;
            idx = 3'h2;
        end else if (reg_req.addr == ADDR_COMB3_B) begin
            kind = K_OPB;
            idx = 3'h2;
        end else if (reg_req.addr == ADDR_COMB3_OP) begin
            kind = K_OPER;
            idx = 3'h2;
        end else if (reg_req.addr >= ADDR_IN1_FILT && reg_req.addr <= ADDR_IN7_FILT) begin
            kind = K_FILT;
            idx = 3'(reg_req.addr - ADDR_IN1_FILT);
        end else if (reg_req.addr == ADDR_MSEL_SETTLE) begin
            kind = K_MSEL;
        end
    end

    // Operand lookup; illegal codes never reach storage
    always_comb begin
        for (int i = 0; i < COMB_NUM; i++) begin
            opa_val[i] = func_state[s_r.opa[i][FIDX_W-1:0]];
            opb_val[i] = func_state[s_r.opb[i][FIDX_W-1:0]];
        end
    end

    // Register access, combiners and overload compare
    always_comb begin
        logic ok;
        logic [15:0] rval;
        logic [15:0] wd;
        ok = 1'b1;
        rval = REG_RST;
        wd = reg_req.wdata;
        s_nxt = s_r;
        case (kind)
            K_THR: begin
                rval = s_r.thr;
                ok = wd <= THR_MAX;
                if (reg_req.wr && ok) begin
                    s_nxt.thr = wd;
                end
            end
            K_ON: begin
                rval = s_r.dly_on[idx[1:0]];
                ok = wd <= DELAY_MAX;
                if (reg_req.wr && ok) begin
                    s_nxt.dly_on[idx[1:0]] = wd;
                end
            end
            K_OFF: begin
                rval = s_r.dly_off[idx[1:0]];
                ok = wd <= DELAY_MAX;
                if (reg_req.wr && ok) begin
                    s_nxt.dly_off[idx[1:0]] = wd;
                end
            end
            K_OPA: begin
                rval = s_r.opa[idx[1:0]];
                ok = opnd_ok(wd);
                if (reg_req.wr && ok) begin
                    s_nxt.opa[idx[1:0]] = wd;
                end
            end
            K_OPB: begin
                rval = s_r.opb[idx[1:0]];
                ok = opnd_ok(wd);
                if (reg_req.wr && ok) begin
                    s_nxt.opb[idx[1:0]] = wd;
                end
            end
            K_OPER: begin
                rval = {14'h0000, s_r.oper[idx[1:0]]};
                ok = wd <= OPER_MAX;
                if (reg_req.wr && ok) begin
                    s_nxt.oper[idx[1:0]] = wd[1:0];
                end
            end
            K_FILT: begin
                rval = s_r.filt[idx];
                ok = wd <= FILT_MAX;
                if (reg_req.wr && ok) begin
                    s_nxt.filt[idx] = wd;
                end
            end
            K_MSEL: begin
                rval = s_r.msel_settle;
                ok = wd <= FILT_MAX;
                if (reg_req.wr && ok) begin
                    s_nxt.msel_settle = wd;
                end
            end
            default: begin
                ok = 1'b0;
            end
        endcase

        // One-cycle answer to each access
        s_nxt.rsp.ack = reg_req.wr | reg_req.rd;
        s_nxt.rsp.err = (reg_req.wr | reg_req.rd) && (kind == K_NONE || (reg_req.wr && !ok));
        s_nxt.rsp.rdata = (reg_req.rd && kind != K_NONE) ? rval : REG_RST;

        // Three independent combiners
        for (int i = 0; i < COMB_NUM; i++) begin
            case (combine_op_t'(s_r.oper[i]))
                OP_AND: s_nxt.lout[i] = opa_val[i] & opb_val[i];
                OP_OR: s_nxt.lout[i] = opa_val[i] | opb_val[i];
                OP_XOR: s_nxt.lout[i] = opa_val[i] ^ opb_val[i];
                default: s_nxt.lout[i] = 1'b0;
            endcase
        end

        s_nxt.ovl = load_current >= s_r.thr;
    end

    // State register
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign reg_rsp = s_r.rsp;
    assign logic_out = s_r.lout;
    assign ovl_warn2 = s_r.ovl;

    // Delayed intelligent and relay outputs
    delay_timer #(.STEP_CYC(DELAY_STEP_CYC_P)) u_out11 (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .src(out11_src),
        .on_dly(s_r.dly_on[0]),
        .off_dly(s_r.dly_off[0]),
        .dout(out11_pin)
    );

    delay_timer #(.STEP_CYC(DELAY_STEP_CYC_P)) u_out12 (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .src(out12_src),
        .on_dly(s_r.dly_on[1]),
        .off_dly(s_r.dly_off[1]),
        .dout(out12_pin)
    );

    delay_timer #(.STEP_CYC(DELAY_STEP_CYC_P)) u_relay (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .src(relay_src),
        .on_dly(s_r.dly_on[2]),
        .off_dly(s_r.dly_off[2]),
        .dout(relay_output)
    );

    // Input response filters
    for (genvar g = 0; g < IN_NUM; g++) begin : g_in
        settle_filter #(.W(1), .TICK_CYC(SAMPLE_TICK_CYC_P)) u_filt (
            .mclk(mclk),
            .sys_rst(sys_rst),
            .raw(din_raw[g]),
            .settle(s_r.filt[g]),
            .dout(din_filt[g])
        );
    end

    // Multistage selection settle
    settle_filter #(.W(SEL_WIDTH), .TICK_CYC(SAMPLE_TICK_CYC_P)) u_msel (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .raw(msel_raw),
        .settle(s_r.msel_settle),
        .dout(msel_held)
    );

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // Illegal writes aimed at the first combiner and output 11
    sequence s_bad_operand;
        reg_req.wr && reg_req.addr == ADDR_COMB1_A && !opnd_ok(reg_req.wdata);
    endsequence

    sequence s_long_on_delay;
        reg_req.wr && reg_req.addr == ADDR_OUT11_ON && reg_req.wdata > DELAY_MAX;
    endsequence

    // Combiner results one cycle after their operands
    a_oper_and: assert property (
        s_r.oper[0] == OP_AND |=> logic_out[0] == ($past(opa_val[0]) & $past(opb_val[0])))
        else $error("logic output 1 AND result wrong");

    a_oper_xor: assert property (
        s_r.oper[1] == OP_XOR |=> logic_out[1] == ($past(opa_val[1]) ^ $past(opb_val[1])))
        else $error("logic output 2 XOR result wrong");

    a_third_or: assert property (
        s_r.oper[2] == OP_OR |=> logic_out[2] == ($past(opa_val[2]) | $past(opb_val[2])))
        else $error("logic output 3 OR result wrong");

    // Range guards on register writes
    a_operand_guard: assert property (
        s_bad_operand |=> $stable(s_r.opa[0]) && reg_rsp.err && reg_rsp.ack)
        else $error("illegal operand code accepted");

    a_on_range: assert property (
        s_long_on_delay |=> $stable(s_r.dly_on[0]) && reg_rsp.err)
        else $error("out of range on-delay accepted");

    // Delayed output edges and overload compare
    a_off_zero: assert property (
        $fell(relay_src) && relay_output && s_r.dly_off[2] == 16'h0000 |=> !relay_output)
        else $error("relay with zero off-delay did not release");

    a_off_pending: assert property (
        $fell(relay_src) && relay_output && s_r.dly_off[2] != 16'h0000 |=> relay_output)
        else $error("relay released before its off-delay");

    a_on_pending: assert property (
        $rose(out11_src) && !out11_pin && s_r.dly_on[0] != 16'h0000 |=> !out11_pin)
        else $error("output 11 asserted before its on-delay");

    a_ovl_compare: assert property (
        !sys_rst |=> ovl_warn2 == ($past(load_current) >= $past(s_r.thr)))
        else $error("overload warning disagrees with threshold");

    // Filter pass-through and settling, output 11 on-delay cancel
    a_filter_zero: assert property (
        s_r.filt[0] == 16'h0000 |=> din_filt[0] == $past(din_raw[0]))
        else $error("zero response time did not pass input");

    a_msel_zero: assert property (
        s_r.msel_settle == 16'h0000 |=> msel_held == $past(msel_raw))
        else $error("zero settle time did not pass selection");

    a_msel_hold: assert property (
        s_r.msel_settle != 16'h0000 && msel_raw != $past(msel_raw) |=> $stable(msel_held))
        else $error("speed selection taken before settling");

    a_on_cancel: assert property (
        !out11_pin && out11_src && s_r.dly_on[0] != 16'h0000 ##1 !out11_src && !out11_pin
        |=> !out11_pin)
        else $error("cancelled on-delay still asserted output");
endmodule
`default_nettype wire

// ===== tb/reg_master.sv
`default_nettype none
module reg_master
    import terminal_cond_pkg::*;
(
    input wire logic mclk,
    output var reg_req_t reg_req,
    input wire reg_rsp_t reg_rsp
);
    timeunit 1ns;
    timeprecision 1ps;

    reg_rsp_t rsp;

    // Bus idle from time zero
    initial reg_req = '0;

    // One request pulse, then a bounded wait for the answer
    task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge mclk);
        reg_req <= '0;
        #1;
        rsp = reg_rsp;
        for (int i = 0; i < 4 && rsp.ack !== 1'b1; i++) begin
            @(posedge mclk);
            #1;
            rsp = reg_rsp;
        end
    endtask
endmodule
`default_nettype wire

// ===== tb/terminal_conditioner_tb_top.sv
`default_nettype none
module terminal_conditioner_tb_top
    import terminal_cond_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    reg_req_t reg_req;
    reg_rsp_t reg_rsp;
    logic [2:0] src = '0;
    logic [2:0] dly_out;
    logic [63:0] func_state = '0;
    logic [2:0] logic_out;
    logic [6:0] din_raw = '0;
    logic [6:0] din_filt;
    logic [3:0] msel_raw = '0;
    logic [3:0] msel_held;
    logic [15:0] load_current = '0;
    logic ovl_warn2;
    int n_fail = 0;
    int checks_done = 0;
    int cyc = 0;

    // Short steps: delay step 4 cycles, sample tick 3 cycles
    terminal_conditioner #(.DELAY_STEP_CYC_P(4), .SAMPLE_TICK_CYC_P(3)) dut (
        .mclk(mclk), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rsp(reg_rsp),
        .out11_src(src[0]), .out12_src(src[1]), .relay_src(src[2]),
        .out11_pin(dly_out[0]), .out12_pin(dly_out[1]), .relay_output(dly_out[2]),
        .func_state(func_state), .logic_out(logic_out), .din_raw(din_raw),
        .din_filt(din_filt), .msel_raw(msel_raw), .msel_held(msel_held),
        .load_current(load_current), .ovl_warn2(ovl_warn2));

    reg_master mst (.mclk(mclk), .reg_req(reg_req), .reg_rsp(reg_rsp));

    initial forever #10 mclk = ~mclk;

    task automatic close_out();
        if (n_fail == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            close_out();
        end
    end

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Wait n edges, then let them settle
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic e);
        mst.xfer(1'b1, a, d);
        chk("wr ack", 16'(mst.rsp.ack), 16'h0001);
        chk("wr err", 16'(mst.rsp.err), 16'(e));
    endtask

    task automatic rd(input logic [15:0] a, input logic [15:0] d, input logic e);
        mst.xfer(1'b0, a, 16'h0000);
        chk("rd err", 16'(mst.rsp.err), 16'(e));
        chk("rd data", mst.rsp.rdata, d);
    endtask

    // Sweep the whole window: reset value, range edge, gaps refused
    task automatic t_regs();
        logic [15:0] lim;
        logic mp;
        for (int a = 16'h1473; a <= 16'h14AD; a++) begin
            mp = a == ADDR_OVL_THR || (a >= ADDR_OUT11_ON && a <= ADDR_OUT12_OFF)
                || (a >= ADDR_RELAY_ON && a <= ADDR_COMB3_OP)
                || (a >= ADDR_IN1_FILT && a <= ADDR_IN7_FILT) || a == ADDR_MSEL_SETTLE;
            lim = a == ADDR_OVL_THR ? THR_MAX : a <= ADDR_RELAY_OFF ? DELAY_MAX
                : a > ADDR_COMB3_OP ? FILT_MAX
                : (a - ADDR_COMB1_A) % 3 == 2 ? OPER_MAX : 16'h003E;
            rd(16'(a), REG_RST, !mp);
            if (mp) begin
                wr(16'(a), lim + 16'h0001, 1'b1);
                rd(16'(a), REG_RST, 1'b0);
                wr(16'(a), lim, 1'b0);
                rd(16'(a), lim, 1'b0);
            end else begin
                wr(16'(a), 16'h0001, 1'b1);
            end
        end
    endtask

    // On 2 steps, off 1 step, with a cancelled release
    task automatic t_delay();
        for (int k = 0; k < 6; k++) begin
            wr(k < 4 ? 16'(ADDR_OUT11_ON + k) : 16'(ADDR_RELAY_ON + k - 4),
                k % 2 ? 16'h0001 : 16'h0002, 1'b0);
        end
        @(posedge mclk) src <= 3'h7;
        tick(8);
        chk("on early", 16'(dly_out), 16'h0000);
        tick(1);
        chk("on done", 16'(dly_out), 16'h0007);
        @(posedge mclk) src <= 3'h0;
        tick(1);
        @(posedge mclk) src <= 3'h7;
        tick(8);
        chk("cancel", 16'(dly_out), 16'h0007);
        @(posedge mclk) src <= 3'h0;
        tick(4);
        chk("off early", 16'(dly_out), 16'h0007);
        tick(1);
        chk("off done", 16'(dly_out), 16'h0000);
        // Source dropped before the on-delay ends
        @(posedge mclk) src <= 3'h7;
        tick(4);
        @(posedge mclk) src <= 3'h0;
        tick(4);
        chk("on cancel", 16'(dly_out), 16'h0000);
        // Zero off-delay releases the relay on the next edge
        wr(ADDR_RELAY_OFF, 16'h0000, 1'b0);
        @(posedge mclk) src <= 3'h7;
        tick(9);
        chk("on again", 16'(dly_out), 16'h0007);
        @(posedge mclk) src <= 3'h0;
        tick(1);
        chk("off zero", 16'(dly_out), 16'h0003);
    endtask

    // Three combiners on the same operands, one operator each
    task automatic t_comb();
        logic [15:0] bad [5] = '{FUNC_LOG_FIRST, FUNC_LOG_LAST, FUNC_OPT_BOARD,
            FUNC_NONE, FUNC_NUM};
        for (int k = 0; k < 3; k++) begin
            wr(16'(ADDR_COMB1_A + 3 * k), 16'h0001, 1'b0);
            wr(16'(ADDR_COMB1_B + 3 * k), 16'h0002, 1'b0);
            wr(16'(ADDR_COMB1_OP + 3 * k), 16'(2 * k % 3), 1'b0);
        end
        foreach (bad[i]) wr(ADDR_COMB2_A, bad[i], 1'b1);
        wr(ADDR_COMB1_OP, 16'h0003, 1'b1);
        rd(ADDR_COMB2_A, 16'h0001, 1'b0);
        for (int v = 0; v < 4; v++) begin
            @(posedge mclk) func_state <= 64'(v << 1);
            tick(2);
            chk("logic_out", 16'(logic_out),
                16'({v[0] | v[1], v[0] ^ v[1], v[0] & v[1]}));
        end
    endtask

    // Glitches shorter than the settle time are dropped
    task automatic t_filt();
        for (int k = 0; k < 7; k++) wr(16'(ADDR_IN1_FILT + k), 16'(k > 0), 1'b0);
        wr(ADDR_MSEL_SETTLE, 16'h0002, 1'b0);
        @(posedge mclk) din_raw <= 7'h7F;
        msel_raw <= 4'hA;
        tick(2);
        chk("din zero time", 16'(din_filt), 16'h0001);
        @(posedge mclk) din_raw <= 7'h00;
        tick(1);
        @(posedge mclk) msel_raw <= 4'h0;
        tick(8);
        chk("din glitch", 16'(din_filt), 16'h0000);
        chk("msel glitch", 16'(msel_held), 16'h0000);
        @(posedge mclk) din_raw <= 7'h7F;
        msel_raw <= 4'hA;
        tick(12);
        chk("din held", 16'(din_filt), 16'h007F);
        chk("msel held", 16'(msel_held), 16'h000A);
    endtask

    // Warning at and above the threshold only
    task automatic t_ovl();
        wr(ADDR_OVL_THR, 16'h0064, 1'b0);
        @(posedge mclk) load_current <= 16'h0063;
        tick(2);
        chk("ovl below", 16'(ovl_warn2), 16'h0000);
        @(posedge mclk) load_current <= 16'h0064;
        tick(2);
        chk("ovl at", 16'(ovl_warn2), 16'h0001);
    endtask

    // Main sequence
    initial begin
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        t_regs();
        t_delay();
        t_comb();
        t_filt();
        t_ovl();
        close_out();
    end
endmodule
`default_nettype wire
